// ### include/dcq_defs.vh
`ifndef DCQ_DEFS_VH
`define DCQ_DEFS_VH

// Default geometry
`define DCQ_DATA_W        8
`define DCQ_ADDR_W        4

// Clear release: domain stays in clear for this many of its own clock edges
`define DCQ_CLR_STAGES    3

// Pointer crossing depth
`define DCQ_SYNC_STAGES   2

// Read modes
`define DCQ_MODE_NORMAL   1'b0
`define DCQ_MODE_LOOKAHD  1'b1

// Reset values
`define DCQ_FULL_RST      1'b0
`define DCQ_EMPTY_RST     1'b1
`define DCQ_DATA_RST      1'b0

`endif

// ### logic/dcq_clr_sync.v
`timescale 1ns/100ps
`default_nettype none
`include "dcq_defs.vh"

module dcq_clr_sync #(
  parameter ENABLE = 1,
  parameter STAGES = `DCQ_CLR_STAGES
) (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        aclr,
  input  wire        tick,
  output wire        busy
);

  reg [STAGES-1:0] sh_q;

  // Set at once by the clear, drained by the domain's own edges after release
  always @(posedge clock or posedge aclr) begin
    if (aclr) begin
      sh_q <= {STAGES{1'b1}};
    end else if (!rst_b) begin
      sh_q <= {STAGES{1'b1}};
    end else if (tick) begin
      sh_q <= {sh_q[STAGES-2:0], 1'b0};
    end
  end

  // Without the option the domain leaves clear on the first edge after release
  assign busy = (ENABLE != 0) ? sh_q[STAGES-1] : 1'b0;

endmodule

`default_nettype wire

// ### logic/dcq_gray_sync.v
`timescale 1ns/100ps
`default_nettype none
`include "dcq_defs.vh"

module dcq_gray_sync #(
  parameter WIDTH = `DCQ_ADDR_W + 1
) (
  input  wire             clock,
  input  wire             rst_b,
  input  wire             aclr,
  input  wire             tick,
  input  wire [WIDTH-1:0] gray_in,
  output wire [WIDTH-1:0] gray_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // Only the second stage is looked at downstream
  always @(posedge clock or posedge aclr) begin
    if (aclr) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else if (!rst_b) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else if (tick) begin
      meta_q <= gray_in;
      sync_q <= meta_q;
    end
  end

  assign gray_out = sync_q;

endmodule

`default_nettype wire

// ### logic/dcq_fifo.v
// Behaviour
// - Clear drops write-side and read-side full flags.
// - Clear raises write-side and read-side empty flags.
// - Clear zeroes both fill-level counts.
// - Status effects of clear act at once, no clock edge needed.
// - Clear returns read and write pointers to zero.
// - With write sync, write full stays high three write edges after release.
// - With read sync, read empty stays high three read edges after release.
// - Even with sync, all flags change immediately when clear asserts.
// - Write-side sync parameter adds release synchroniser on write clock.
// - Read-side sync parameter adds release synchroniser on read clock.
// - Normal mode: clear keeps unregistered output, clears registered output.
// - Look-ahead mode: unregistered output undefined after clear, registered cleared.
// - Normal mode reads only in cycles with read request asserted.
// - Look-ahead mode shows oldest word whenever not empty, without request.
// - Look-ahead read request pops shown word and shows the next.
// - Output register option independent of read mode.
// - Pointers cross domains in gray code, one bit change per step.
//
`timescale 1ns/100ps
`default_nettype none
`include "dcq_defs.vh"

module dcq_fifo #(
  parameter DATA_W                      = `DCQ_DATA_W,
  parameter ADDR_W                      = `DCQ_ADDR_W,
  parameter LOOKAHEAD                   = 0,
  parameter OUT_REG                     = 1,
  parameter write_side_clear_sync_enable = 1,
  parameter read_side_clear_sync_enable  = 1
) (
  input  wire              clock,
  input  wire              rst_b,
  input  wire              aclr,
  input  wire              wr_clk,
  input  wire              wr_req,
  input  wire [DATA_W-1:0] wr_data,
  output wire              wr_full,
  output wire              wr_empty,
  output wire [ADDR_W:0]   wr_used,
  input  wire              rd_clk,
  input  wire              rd_req,
  output wire [DATA_W-1:0] rd_data,
  output wire              rd_full,
  output wire              rd_empty,
  output wire [ADDR_W:0]   rd_used
);

  localparam DEPTH = 1 << ADDR_W;
  localparam PW    = ADDR_W + 1;

  function [PW-1:0] bin2gray;
    input [PW-1:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [PW-1:0] gray2bin;
    input [PW-1:0] g;
    integer i;
    begin
      gray2bin[PW-1] = g[PW-1];
      for (i = PW - 2; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Domain edges: both side clocks are sampled and their rising edges become ticks

  reg wclk_s_q;
  reg wclk_p_q;
  reg rclk_s_q;
  reg rclk_p_q;

  always @(posedge clock) begin
    if (!rst_b) begin
      wclk_s_q <= 1'b0;
      wclk_p_q <= 1'b0;
      rclk_s_q <= 1'b0;
      rclk_p_q <= 1'b0;
    end else begin
      wclk_s_q <= wr_clk;
      wclk_p_q <= wclk_s_q;
      rclk_s_q <= rd_clk;
      rclk_p_q <= rclk_s_q;
    end
  end

  wire wr_tick = wclk_s_q & ~wclk_p_q;
  wire rd_tick = rclk_s_q & ~rclk_p_q;

  //////////////////////////////////////////////////////////////////////////////
  // Clear release per domain

  wire wr_busy;
  wire rd_busy;

  dcq_clr_sync #(
    .ENABLE (write_side_clear_sync_enable),
    .STAGES (`DCQ_CLR_STAGES)
  ) u_wr_clr (
    .clock (clock),
    .rst_b (rst_b),
    .aclr  (aclr),
    .tick  (wr_tick),
    .busy  (wr_busy)
  );

  dcq_clr_sync #(
    .ENABLE (read_side_clear_sync_enable),
    .STAGES (`DCQ_CLR_STAGES)
  ) u_rd_clr (
    .clock (clock),
    .rst_b (rst_b),
    .aclr  (aclr),
    .tick  (rd_tick),
    .busy  (rd_busy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Storage and pointers

  reg [DATA_W-1:0] mem [0:DEPTH-1];
  reg [PW-1:0]     wbin_q;
  reg [PW-1:0]     wgray_q;
  reg [PW-1:0]     rbin_q;
  reg [PW-1:0]     rgray_q;
  reg              wr_full_q;
  reg              wr_empty_q;
  reg [PW-1:0]     wr_used_q;
  reg              rd_full_q;
  reg              rd_empty_q;
  reg [PW-1:0]     rd_used_q;

  // Flags are exact for own pointer and pessimistic for the far one
  wire wr_ok = wr_tick & wr_req & ~wr_full_q & ~wr_busy;
  wire rd_ok = rd_tick & rd_req & ~rd_empty_q & ~rd_busy;

  wire [PW-1:0] wbin_d = wbin_q + {{ADDR_W{1'b0}}, wr_ok};
  wire [PW-1:0] rbin_d = rbin_q + {{ADDR_W{1'b0}}, rd_ok};

  always @(posedge clock) begin
    if (wr_ok) begin
      mem[wbin_q[ADDR_W-1:0]] <= wr_data;
    end
  end

  always @(posedge clock or posedge aclr) begin
    if (aclr) begin
      wbin_q  <= {PW{1'b0}};
      wgray_q <= {PW{1'b0}};
      rbin_q  <= {PW{1'b0}};
      rgray_q <= {PW{1'b0}};
    end else if (!rst_b) begin
      wbin_q  <= {PW{1'b0}};
      wgray_q <= {PW{1'b0}};
      rbin_q  <= {PW{1'b0}};
      rgray_q <= {PW{1'b0}};
    end else begin
      wbin_q  <= wbin_d;
      wgray_q <= bin2gray(wbin_d);
      rbin_q  <= rbin_d;
      rgray_q <= bin2gray(rbin_d);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pointer crossing

  wire [PW-1:0] rgray_at_w;
  wire [PW-1:0] wgray_at_r;

  dcq_gray_sync #(
    .WIDTH (PW)
  ) u_r2w (
    .clock    (clock),
    .rst_b    (rst_b),
    .aclr     (aclr),
    .tick     (wr_tick),
    .gray_in  (rgray_q),
    .gray_out (rgray_at_w)
  );

  dcq_gray_sync #(
    .WIDTH (PW)
  ) u_w2r (
    .clock    (clock),
    .rst_b    (rst_b),
    .aclr     (aclr),
    .tick     (rd_tick),
    .gray_in  (wgray_q),
    .gray_out (wgray_at_r)
  );

  wire [PW-1:0] wr_used_d = wbin_d - gray2bin(rgray_at_w);
  wire [PW-1:0] rd_used_d = gray2bin(wgray_at_r) - rbin_d;

  //////////////////////////////////////////////////////////////////////////////
  // Status: async-clear flops, so the clear acts without a clock edge

  always @(posedge clock or posedge aclr) begin
    if (aclr) begin
      wr_full_q  <= `DCQ_FULL_RST;
      rd_full_q  <= `DCQ_FULL_RST;
      wr_empty_q <= `DCQ_EMPTY_RST;
      rd_empty_q <= `DCQ_EMPTY_RST;
      wr_used_q  <= {PW{1'b0}};
      rd_used_q  <= {PW{1'b0}};
    end else if (!rst_b) begin
      wr_full_q  <= `DCQ_FULL_RST;
      rd_full_q  <= `DCQ_FULL_RST;
      wr_empty_q <= `DCQ_EMPTY_RST;
      rd_empty_q <= `DCQ_EMPTY_RST;
      wr_used_q  <= {PW{1'b0}};
      rd_used_q  <= {PW{1'b0}};
    end else begin
      wr_full_q  <= wr_used_d[ADDR_W] | wr_busy;
      wr_empty_q <= (wr_used_d == {PW{1'b0}});
      wr_used_q  <= wr_used_d;
      rd_full_q  <= rd_used_d[ADDR_W];
      rd_empty_q <= (rd_used_d == {PW{1'b0}}) | rd_busy;
      rd_used_q  <= rd_used_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data
  // Normal: word loaded only on an accepted read.
  // Look-ahead: word under the next read pointer is shown every cycle.

  reg  [DATA_W-1:0] q_raw_q;
  reg  [DATA_W-1:0] q_reg_q;
  wire              q_load = (LOOKAHEAD != 0) ? 1'b1 : rd_ok;
  wire [DATA_W-1:0] q_src  = (LOOKAHEAD != 0) ? mem[rbin_d[ADDR_W-1:0]]
                                              : mem[rbin_q[ADDR_W-1:0]];

  // Not touched by the clear: keeps its word in normal mode, and in
  // look-ahead it shows stale storage until a valid write arrives
  always @(posedge clock) begin
    if (!rst_b) begin
      q_raw_q <= {DATA_W{`DCQ_DATA_RST}};
    end else if (q_load) begin
      q_raw_q <= q_src;
    end
  end

  always @(posedge clock or posedge aclr) begin
    if (aclr) begin
      q_reg_q <= {DATA_W{`DCQ_DATA_RST}};
    end else if (!rst_b) begin
      q_reg_q <= {DATA_W{`DCQ_DATA_RST}};
    end else if (q_load) begin
      q_reg_q <= q_src;
    end
  end

  assign rd_data  = (OUT_REG != 0) ? q_reg_q : q_raw_q;
  assign wr_full  = wr_full_q;
  assign wr_empty = wr_empty_q;
  assign wr_used  = wr_used_q;
  assign rd_full  = rd_full_q;
  assign rd_empty = rd_empty_q;
  assign rd_used  = rd_used_q;

endmodule

`default_nettype wire

// ### bench/dcq_fifo_props.sv
`timescale 1ns/100ps
`default_nettype none
module dcq_fifo_props #(
  parameter DATA_W    = 8,
  parameter ADDR_W    = 4,
  parameter LOOKAHEAD = 0,
  parameter OUT_REG   = 1
) (
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic              aclr,
  input wire logic              wr_full,
  input wire logic              wr_empty,
  input wire logic [ADDR_W:0]   wr_used,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              rd_full,
  input wire logic              rd_empty,
  input wire logic [ADDR_W:0]   rd_used
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_clr_full; aclr |-> !wr_full && !rd_full; endproperty
  a_clr_full: assert property (p_clr_full) else $error("full flag up during clear");
  property p_clr_empty; aclr |-> wr_empty && rd_empty; endproperty
  a_clr_empty: assert property (p_clr_empty) else $error("empty flag low in clear");
  property p_clr_used; aclr |-> wr_used == 0 && rd_used == 0; endproperty
  a_clr_used: assert property (p_clr_used) else $error("fill level kept in clear");
  property p_clr_data; OUT_REG != 0 && aclr |-> rd_data == 0; endproperty
  a_clr_data: assert property (p_clr_data) else $error("output register kept");
  property p_wr_hold; $fell(aclr) |=> wr_full [*3]; endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write side left clear early");
  property p_rd_hold; $fell(aclr) |=> rd_empty [*3]; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read side left clear early");
  // A read may still lower the write-side level while full, so only growth is illegal
  property p_full_ign; wr_full && !aclr ##1 !aclr |-> wr_used <= $past(wr_used); endproperty
  a_full_ign: assert property (p_full_ign) else $error("write taken while full");
  property p_empty_ign;
    LOOKAHEAD == 0 && rd_empty && !aclr ##1 !aclr |-> $stable(rd_data);
  endproperty
  a_empty_ign: assert property (p_empty_ign) else $error("read taken while empty");
endmodule
bind dcq_fifo dcq_fifo_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LOOKAHEAD(LOOKAHEAD),
  .OUT_REG(OUT_REG)) u_props (.clock(clock), .rst_b(rst_b), .aclr(aclr), .wr_full(wr_full),
  .wr_empty(wr_empty), .wr_used(wr_used), .rd_data(rd_data), .rd_full(rd_full),
  .rd_empty(rd_empty), .rd_used(rd_used));
`default_nettype wire

// ### bench/dcq_user.sv
`timescale 1ns/100ps
`default_nettype none
// Writer and reader clocks: unrelated periods of 4 and 6 system clocks
module dcq_user (
  input  wire logic clock,
  output wire logic wr_clk,
  output wire logic rd_clk
);
  logic [1:0] wdiv_q = 2'h0;
  logic [2:0] rdiv_q = 3'h0;
  always @(posedge clock) begin
    wdiv_q <= wdiv_q + 2'h1;
    rdiv_q <= (rdiv_q == 3'h5) ? 3'h0 : rdiv_q + 3'h1;
  end
  assign wr_clk = wdiv_q[1];
  assign rd_clk = (rdiv_q > 3'h2);
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic             clock = 1'b0;
  logic             rst_b = 1'b0;
  logic             aclr = 1'b0;
  logic             wr_req = 1'b0;
  logic             rd_req = 1'b0;
  logic [7:0]       wr_data = 8'h00;
  logic [7:0]       d;
  logic [7:0]       exp_q = 8'h00;
  logic [7:0]       fifo_q [$];
  wire logic        wr_clk, rd_clk, wr_full, wr_empty, rd_full, rd_empty;
  wire logic [4:0]  wr_used, rd_used;
  wire logic [7:0]  rd_data, rd_data2;
  integer           n_mismatch = 0;
  integer           comparisons = 0;
  integer           cycles = 0;
  integer           i;
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end
  dcq_user u_user (.clock(clock), .wr_clk(wr_clk), .rd_clk(rd_clk));
  dcq_fifo uut (.clock(clock), .rst_b(rst_b), .aclr(aclr), .wr_clk(wr_clk), .wr_req(wr_req),
    .wr_data(wr_data), .wr_full(wr_full), .wr_empty(wr_empty), .wr_used(wr_used),
    .rd_clk(rd_clk), .rd_req(rd_req), .rd_data(rd_data), .rd_full(rd_full),
    .rd_empty(rd_empty), .rd_used(rd_used));
  dcq_fifo #(.LOOKAHEAD(1), .OUT_REG(0)) uut_la (.clock(clock), .rst_b(rst_b), .aclr(aclr),
    .wr_clk(wr_clk), .wr_req(wr_req), .wr_data(wr_data), .wr_full(), .wr_empty(),
    .wr_used(), .rd_clk(rd_clk), .rd_req(rd_req), .rd_data(rd_data2), .rd_full(),
    .rd_empty(), .rd_used());
  ////////////////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Four clocks of request hold exactly one write tick of the 4-clock writer
  task wr_burst(input integer n);
    wr_req <= 1'b1;
    for (i = 0; i < n; i = i + 1) begin
      d = 8'($urandom);
      wr_data <= d;
      if (fifo_q.size() < 16)
        fifo_q.push_back(d);
      repeat (4) @(posedge clock);
    end
    wr_req <= 1'b0;
  endtask
  // A quiet gap after each read lets the normal-mode output settle before it is compared
  task rd_one;
    if (fifo_q.size() > 0) begin
      chk(rd_data2, fifo_q[0]);
      exp_q = fifo_q.pop_front();
    end
    rd_req <= 1'b1;
    repeat (6) @(posedge clock);
    rd_req <= 1'b0;
    repeat (6) @(posedge clock);
    chk(rd_data, exp_q);
  endtask
  task stop_test;
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    wr_data <= 8'($urandom(32'h6fb3353e));
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (40) @(posedge clock);
    chk({wr_full, rd_full, wr_empty, rd_empty}, 4'h3);
    chk({wr_used, rd_used}, 10'h000);
    $display("test reset status done");
    wr_burst(17);
    repeat (30) @(posedge clock);
    chk({wr_full, rd_full, wr_used, rd_used}, 12'he10);
    chk(rd_data2, fifo_q[0]);
    #3 aclr = 1'b1;
    #1;
    chk({wr_full, rd_full, wr_empty, rd_empty}, 4'h3);
    chk({wr_used, rd_used, rd_data}, 18'h00000);
    repeat (3) @(posedge clock);
    // Both requests are low across the release edge
    #3 aclr = 1'b0;
    @(posedge clock);
    #1;
    chk({wr_full, rd_empty}, 2'h3);
    fifo_q.delete();
    repeat (40) @(posedge clock);
    chk({wr_full, wr_empty, wr_used}, 7'h20);
    $display("test clear done");
    wr_burst(16);
    repeat (30) @(posedge clock);
    for (int k = 0; k < 17; k = k + 1)
      rd_one;
    chk({rd_empty, rd_used}, 6'h20);
    $display("test fill and drain done");
    stop_test;
  end
endmodule
`default_nettype wire
